// ---- hw/tmas_top.sv ----
// Purpose: control, status and interrupt logic around an 8-bit timer/counter
// Assumes: counter core outside; its events and live count arrive on the io clock
// Notes: registers reached over classic Wishbone, ack one cycle after request
// Function
// - external clock buffer on when external-clock enable and async select both set
// - crystal oscillator runs only while external-clock enable is zero
// - async select zero uses io clock, one uses crystal or external clock
// - async select sticks only when system clock is RC or watchdog oscillator
// - async counter write sets its busy flag, cleared once counter loaded
// - async compare a write sets its busy flag, cleared once loaded
// - async control a/b writes set own busy flag, cleared once loaded
// - counter reads live value; compare and controls read holding registers
// - reserved bits of status, mask, flag, general control read zero
// - compare interrupt requested when enable, global enable and flag all one
// - overflow interrupt requested when enable, global enable and flag all one
// - compare flag set on match, cleared by vector or writing one
// - overflow flag set on overflow, cleared by vector or writing one
// - in phase-correct mode overflow flag sets on reversal at bottom
// - writing one to timer-zero prescaler reset resets it, then self-clears
// - in async mode prescaler reset bit stays until reset completed
// - while sync hold set, prescaler reset bits are not cleared
// - writing sync hold zero clears both prescaler reset bits together
//
// Decided for this implementation: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns
`include "tmas_cfg.svh"

module tmas_top
  import tmas_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic async_clk_i,
  input wire logic clk_src_ok_i,
  input wire logic gie_i,
  input wire logic [7:0] cnt_live_i,
  input wire logic cmp_match_i,
  input wire logic max_wrap_i,
  input wire logic bottom_turn_i,
  input wire logic cmp_vec_ack_i,
  input wire logic ovf_vec_ack_i,
  output logic cnt_load_o,
  output logic [7:0] cnt_load_val_o,
  output logic [7:0] cmp_a_o,
  output logic [7:0] ctrl_a_o,
  output logic [7:0] ctrl_b_o,
  output logic force_cmp_o,
  output logic [1:0] tmr_clk_src_o,
  output logic ext_buf_en_o,
  output logic osc_run_o,
  output logic prescaler_reset_timer_zero_o,
  output logic prescaler_reset_timer_one_o,
  output logic irq_cmp_o,
  output logic irq_ovf_o
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] pad8(input tmas_byte_t v);
    pad8 = {24'h00_0000, v};
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic ack_r;
  logic [31:0] dat_r;
  logic ext_r;
  logic as_r;
  logic ocie_r;
  logic toie_r;
  logic ocf_r;
  logic tov_r;
  logic tsm_r;
  logic prescaler_reset_timer_zero_r;
  logic prescaler_reset_timer_one_r;
  tmas_byte_t cnt_tmp_r;
  tmas_byte_t cmp_tmp_r;
  tmas_byte_t cta_tmp_r;
  tmas_byte_t ctb_tmp_r;
  tmas_byte_t cmp_act_r;
  tmas_byte_t cta_act_r;
  tmas_byte_t ctb_act_r;
  logic cnt_load_r;
  tmas_byte_t cnt_val_r;
  logic force_r;
  tmas_src_e src_r;
  logic ext_buf_r;
  logic osc_run_r;
  logic irq_cmp_r;
  logic irq_ovf_r;

  tmas_xfer_if xif ();

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire req;
  wire wr_go;
  wire tmas_byte_t wd;
  wire hit_async_clock_status;
  wire hit_mask;
  wire hit_flag;
  wire hit_gtc;
  wire hit_cnt;
  wire hit_cmp;
  wire hit_cta;
  wire hit_ctb;
  wire wr_async_clock_status;
  wire wr_mask;
  wire wr_flag;
  wire wr_gtc;
  wire wr_cnt;
  wire wr_cmp;
  wire wr_cta;
  wire wr_ctb;

  assign req = wb_cyc_i & wb_stb_i;
  // a write takes effect on the edge where the master sees ack
  assign wr_go = req & wb_we_i & ack_r & wb_sel_i[0];
  assign wd = wb_dat_i[7:0];

  assign hit_async_clock_status = (wb_adr_i == `TMAS_OFF_ASYNC_CLOCK_STATUS);
  assign hit_mask = (wb_adr_i == `TMAS_OFF_MASK);
  assign hit_flag = (wb_adr_i == `TMAS_OFF_FLAG);
  assign hit_gtc = (wb_adr_i == `TMAS_OFF_GTC);
  assign hit_cnt = (wb_adr_i == `TMAS_OFF_CNT);
  assign hit_cmp = (wb_adr_i == `TMAS_OFF_CMPA);
  assign hit_cta = (wb_adr_i == `TMAS_OFF_CTLA);
  assign hit_ctb = (wb_adr_i == `TMAS_OFF_CTLB);

  assign wr_async_clock_status = wr_go & hit_async_clock_status;
  assign wr_mask = wr_go & hit_mask;
  assign wr_flag = wr_go & hit_flag;
  assign wr_gtc = wr_go & hit_gtc;
  assign wr_cnt = wr_go & hit_cnt;
  assign wr_cmp = wr_go & hit_cmp;
  assign wr_cta = wr_go & hit_cta;
  assign wr_ctb = wr_go & hit_ctb;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  wire tmas_byte_t rd_async_clock_status;
  wire tmas_byte_t rd_mask;
  wire tmas_byte_t rd_flag;
  wire tmas_byte_t rd_gtc;
  wire [31:0] rdata;

  assign rd_async_clock_status = {1'b0, ext_r, as_r, xif.busy[0], xif.busy[1],
                    1'b0, xif.busy[2], xif.busy[3]};
  assign rd_mask = {6'h00, ocie_r, toie_r};
  assign rd_flag = {6'h00, ocf_r, tov_r};
  assign rd_gtc = {tsm_r, 5'h00, prescaler_reset_timer_zero_r, prescaler_reset_timer_one_r};

  assign rdata = hit_async_clock_status ? pad8(rd_async_clock_status) :
                 hit_mask ? pad8(rd_mask) :
                 hit_flag ? pad8(rd_flag) :
                 hit_gtc ? pad8(rd_gtc) :
                 hit_cnt ? pad8(cnt_live_i) :
                 hit_cmp ? pad8(cmp_tmp_r) :
                 hit_cta ? pad8(cta_tmp_r & `TMAS_MASK_CTLA) :
                 hit_ctb ? pad8(ctb_tmp_r & `TMAS_MASK_CTLB) :
                 32'h0000_0000;

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r) begin
        dat_r <= rdata;
      end
    end
  end

  // ----------------------------------------
  // async transfer hand-off
  // ----------------------------------------
  wire [3:0] wr_held;

  assign wr_held = {wr_ctb, wr_cta, wr_cmp, wr_cnt};
  assign xif.async_mode = as_r;
  assign xif.req = wr_held & {4{as_r}};

  tmas_xfer u_xfer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_clk_i(async_clk_i),
    .xif(xif)
  );

  // ----------------------------------------
  // clock source selection
  // ----------------------------------------
  wire as_nxt;
  wire tmas_src_e src_nxt;

  // a one only sticks while the system clock allows switching
  assign as_nxt = (wr_async_clock_status ? wd[`TMAS_B_AS] : as_r) & clk_src_ok_i;
  assign src_nxt = ~as_r ? TMAS_SRC_IO :
                   ext_r ? TMAS_SRC_EXT : TMAS_SRC_XTAL;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_r <= 1'b0;
      as_r <= 1'b0;
      src_r <= TMAS_SRC_IO;
      ext_buf_r <= 1'b0;
      osc_run_r <= 1'b1;
    end else begin
      if (wr_async_clock_status) begin
        ext_r <= wd[`TMAS_B_EXT];
      end
      as_r <= as_nxt;
      src_r <= src_nxt;
      ext_buf_r <= ext_r & as_r;
      osc_run_r <= ~ext_r;
    end
  end

  // ----------------------------------------
  // holding and active registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_tmp_r <= `TMAS_RST_BYTE;
      cmp_tmp_r <= `TMAS_RST_BYTE;
      cta_tmp_r <= `TMAS_RST_BYTE;
      ctb_tmp_r <= `TMAS_RST_BYTE;
    end else begin
      if (wr_cnt) begin
        cnt_tmp_r <= wd;
      end
      if (wr_cmp) begin
        cmp_tmp_r <= wd;
      end
      if (wr_cta) begin
        cta_tmp_r <= wd & `TMAS_MASK_CTLA;
      end
      if (wr_ctb) begin
        ctb_tmp_r <= wd;
      end
    end
  end

  wire sync_cnt;
  wire sync_cmp;
  wire sync_cta;
  wire sync_ctb;

  assign sync_cnt = wr_cnt & ~as_r;
  assign sync_cmp = wr_cmp & ~as_r;
  assign sync_cta = wr_cta & ~as_r;
  assign sync_ctb = wr_ctb & ~as_r;

  // synchronous writes land at once; held ones on a commit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_act_r <= `TMAS_RST_BYTE;
      cta_act_r <= `TMAS_RST_BYTE;
      ctb_act_r <= `TMAS_RST_BYTE;
      cnt_load_r <= 1'b0;
      cnt_val_r <= `TMAS_RST_BYTE;
      force_r <= 1'b0;
    end else begin
      if (sync_cmp) begin
        cmp_act_r <= wd;
      end else if (xif.commit[1]) begin
        cmp_act_r <= cmp_tmp_r;
      end
      if (sync_cta) begin
        cta_act_r <= wd & `TMAS_MASK_CTLA;
      end else if (xif.commit[2]) begin
        cta_act_r <= cta_tmp_r;
      end
      if (sync_ctb) begin
        ctb_act_r <= wd & `TMAS_MASK_CTLB;
      end else if (xif.commit[3]) begin
        ctb_act_r <= ctb_tmp_r & `TMAS_MASK_CTLB;
      end
      cnt_load_r <= sync_cnt | xif.commit[0];
      cnt_val_r <= sync_cnt ? wd : cnt_tmp_r;
      // force is a strobe; only the control b holding register keeps it as state
      force_r <= (sync_ctb & wd[`TMAS_B_FORCE]) |
                 (xif.commit[3] & ctb_tmp_r[`TMAS_B_FORCE]);
    end
  end

  // ----------------------------------------
  // interrupt enables and flags
  // ----------------------------------------
  wire phase_pwm;
  wire ovf_evt;
  wire ocf_nxt;
  wire tov_nxt;

  assign phase_pwm = ~cta_act_r[`TMAS_B_WGM1] & cta_act_r[`TMAS_B_WGM0];
  assign ovf_evt = phase_pwm ? bottom_turn_i : max_wrap_i;
  // a new event wins over a clear in the same cycle
  assign ocf_nxt = cmp_match_i |
                   (ocf_r & ~(wr_flag & wd[`TMAS_B_CMPA]) & ~cmp_vec_ack_i);
  assign tov_nxt = ovf_evt |
                   (tov_r & ~(wr_flag & wd[`TMAS_B_OVF]) & ~ovf_vec_ack_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ocie_r <= 1'b0;
      toie_r <= 1'b0;
      ocf_r <= 1'b0;
      tov_r <= 1'b0;
      irq_cmp_r <= 1'b0;
      irq_ovf_r <= 1'b0;
    end else begin
      if (wr_mask) begin
        ocie_r <= wd[`TMAS_B_CMPA];
        toie_r <= wd[`TMAS_B_OVF];
      end
      ocf_r <= ocf_nxt;
      tov_r <= tov_nxt;
      irq_cmp_r <= ocie_r & gie_i & ocf_r;
      irq_ovf_r <= toie_r & gie_i & tov_r;
    end
  end

  // ----------------------------------------
  // prescaler reset and sync hold
  // ----------------------------------------
  wire tsm_release;
  wire prescaler_reset_timer_zero_done;

  assign tsm_release = wr_gtc & tsm_r & ~wd[`TMAS_B_TSM];
  // in async mode the prescaler sits on the timer clock, so wait for its edge
  assign prescaler_reset_timer_zero_done = ~as_r | xif.tick;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tsm_r <= 1'b0;
      prescaler_reset_timer_zero_r <= 1'b0;
      prescaler_reset_timer_one_r <= 1'b0;
    end else begin
      if (wr_gtc) begin
        tsm_r <= wd[`TMAS_B_TSM];
      end
      if (tsm_release) begin
        prescaler_reset_timer_zero_r <= 1'b0;
        prescaler_reset_timer_one_r <= 1'b0;
      end else if (wr_gtc) begin
        prescaler_reset_timer_zero_r <= wd[`TMAS_B_PRESCALER_RESET_TIMER_ZERO];
        prescaler_reset_timer_one_r <= wd[`TMAS_B_PRESCALER_RESET_TIMER_ONE];
      end else if (~tsm_r) begin
        if (prescaler_reset_timer_zero_done) begin
          prescaler_reset_timer_zero_r <= 1'b0;
        end
        prescaler_reset_timer_one_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign cnt_load_o = cnt_load_r;
  assign cnt_load_val_o = cnt_val_r;
  assign cmp_a_o = cmp_act_r;
  assign ctrl_a_o = cta_act_r;
  assign ctrl_b_o = ctb_act_r;
  assign force_cmp_o = force_r;
  assign tmr_clk_src_o = src_r;
  assign ext_buf_en_o = ext_buf_r;
  assign osc_run_o = osc_run_r;
  assign prescaler_reset_timer_zero_o = prescaler_reset_timer_zero_r;
  assign prescaler_reset_timer_one_o = prescaler_reset_timer_one_r;
  assign irq_cmp_o = irq_cmp_r;
  assign irq_ovf_o = irq_ovf_r;

endmodule // tmas_top

// ---- hw/tmas_cfg.svh ----
// Purpose: offsets, field positions and reset values of the timer0 async/status block
// Assumes: 32-bit classic Wishbone, one register per aligned word
// Notes: data sits in bits 7:0, upper bits read as zero
`ifndef TMAS_CFG_SVH
`define TMAS_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TMAS_OFF_ASYNC_CLOCK_STATUS 5'h00
`define TMAS_OFF_MASK 5'h04
`define TMAS_OFF_FLAG 5'h08
`define TMAS_OFF_GTC 5'h0C
`define TMAS_OFF_CNT 5'h10
`define TMAS_OFF_CMPA 5'h14
`define TMAS_OFF_CTLA 5'h18
`define TMAS_OFF_CTLB 5'h1C

// ----------------------------------------
// field positions
// ----------------------------------------
`define TMAS_B_EXT 6
`define TMAS_B_AS 5
`define TMAS_B_CUB 4
`define TMAS_B_OAB 3
`define TMAS_B_CAB 1
`define TMAS_B_CBB 0
`define TMAS_B_CMPA 1
`define TMAS_B_OVF 0
`define TMAS_B_TSM 7
`define TMAS_B_PRESCALER_RESET_TIMER_ZERO 1
`define TMAS_B_PRESCALER_RESET_TIMER_ONE 0
`define TMAS_B_WGM0 0
`define TMAS_B_WGM1 1
`define TMAS_B_FORCE 7

// ----------------------------------------
// reset values and readable-bit masks
// ----------------------------------------
`define TMAS_RST_BYTE 8'h00
`define TMAS_MASK_CTLA 8'hC3
`define TMAS_MASK_CTLB 8'h07

`endif

// ---- hw/tmas_pkg.sv ----
// Purpose: shared types of the timer0 async/status block
// Assumes: nothing
// Notes: constants live in tmas_cfg.svh
package tmas_pkg;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef logic [7:0] tmas_byte_t;

  typedef enum logic [1:0] {
    TMAS_SRC_IO = 2'h0,
    TMAS_SRC_XTAL = 2'h1,
    TMAS_SRC_EXT = 2'h2
  } tmas_src_e;

endpackage

// ---- hw/tmas_xfer_if.sv ----
// Purpose: carries update requests and commits between register file and transfer logic
// Assumes: single clock domain (io clock)
// Notes: bit order is counter, compare a, control a, control b
`timescale 1ns/1ns
interface tmas_xfer_if;
  logic async_mode;
  logic [3:0] req;
  logic [3:0] busy;
  logic [3:0] commit;
  logic tick;

  modport regs (output async_mode, output req, input busy, input commit, input tick);
  modport sync (input async_mode, input req, output busy, output commit, output tick);
endinterface

// ---- hw/tmas_xfer.sv ----
// Purpose: samples the timer clock pin and moves held values across on its edges
// Assumes: timer clock slower than half the io clock
// Notes: busy set wins over a commit in the same cycle
`timescale 1ns/1ns
module tmas_xfer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic async_clk_i,
  tmas_xfer_if.sync xif
);

  // ----------------------------------------
  // timer clock sampling
  // ----------------------------------------
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic tick_r;
  logic [3:0] busy_r;
  logic [3:0] commit_r;
  wire tick_w;
  wire [3:0] fire;
  wire [3:0] flush;
  wire [3:0] busy_nxt;

  assign tick_w = s2_r & ~s3_r;

  // ----------------------------------------
  // busy flags and commits
  // ----------------------------------------
  // a commit waits for a sampled timer edge, or for async mode to drop, then the flag drops with it
  assign fire = {4{tick_w}} & busy_r & ~xif.req;
  assign flush = {4{~xif.async_mode}} & busy_r;
  assign busy_nxt = (busy_r & ~fire & ~flush) | xif.req;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      tick_r <= 1'b0;
      busy_r <= 4'h0;
      commit_r <= 4'h0;
    end else begin
      s1_r <= async_clk_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      tick_r <= tick_w;
      busy_r <= busy_nxt;
      commit_r <= fire | flush;
    end
  end

  assign xif.busy = busy_r;
  assign xif.commit = commit_r;
  assign xif.tick = tick_r;

endmodule // tmas_xfer

// ---- dv/tmas_top_asserts.sv ----
// Purpose: port-level checks of the timer0 async/status block
// Assumes: only the ports of tmas_top are visible
// Notes: bound to every tmas_top instance at the foot of this file
`timescale 1ns/1ns
`include "tmas_cfg.svh"

module tmas_top_asserts
  import tmas_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic clk_src_ok_i,
  input wire logic gie_i,
  input wire logic [7:0] cnt_live_i,
  input wire logic cmp_match_i,
  input wire logic max_wrap_i,
  input wire logic bottom_turn_i,
  input wire logic cmp_vec_ack_i,
  input wire logic ovf_vec_ack_i,
  input wire logic cnt_load_o,
  input wire logic ext_buf_en_o,
  input wire logic osc_run_o,
  input wire logic prescaler_reset_timer_zero_o,
  input wire logic prescaler_reset_timer_one_o,
  input wire logic irq_cmp_o,
  input wire logic irq_ovf_o
);
  logic rd_req;
  assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_cnt_read;
    rd_req && wb_adr_i == `TMAS_OFF_CNT |=> wb_dat_o == {24'h00_0000, $past(cnt_live_i)};
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("counter read is not the live count");

  property p_mf_rsvd;
    rd_req && (wb_adr_i == `TMAS_OFF_MASK || wb_adr_i == `TMAS_OFF_FLAG) |=> wb_dat_o[31:2] == 30'h0000_0000;
  endproperty
  a_mf_rsvd: assert property (p_mf_rsvd) else $error("mask or flag reserved bits set");

  property p_stat_rsvd;
    rd_req && wb_adr_i == `TMAS_OFF_ASYNC_CLOCK_STATUS |=> wb_dat_o[31:7] == 25'h000_0000 && !wb_dat_o[2];
  endproperty
  a_stat_rsvd: assert property (p_stat_rsvd) else $error("status reserved bits set");

  property p_gtc_rsvd;
    rd_req && wb_adr_i == `TMAS_OFF_GTC |=> wb_dat_o[31:8] == 24'h00_0000 && wb_dat_o[6:2] == 5'h00;
  endproperty
  a_gtc_rsvd: assert property (p_gtc_rsvd) else $error("general control reserved bits set");

  property p_buf_osc;
    ext_buf_en_o |-> !osc_run_o;
  endproperty
  a_buf_osc: assert property (p_buf_osc) else $error("oscillator runs with external buffer on");

  property p_async_ok;
    ext_buf_en_o |-> $past(clk_src_ok_i, 2);
  endproperty
  a_async_ok: assert property (p_async_ok) else $error("async select held without valid clock");

  property p_irq_cmp_gie;
    irq_cmp_o |-> $past(gie_i);
  endproperty
  a_irq_cmp_gie: assert property (p_irq_cmp_gie) else $error("compare irq without global enable");

  property p_irq_ovf_gie;
    irq_ovf_o |-> $past(gie_i);
  endproperty
  a_irq_ovf_gie: assert property (p_irq_ovf_gie) else $error("overflow irq without global enable");

  property p_cmp_vec_clr;
    cmp_vec_ack_i && !cmp_match_i |-> ##2 !irq_cmp_o;
  endproperty
  a_cmp_vec_clr: assert property (p_cmp_vec_clr) else $error("compare flag kept after vector");

  property p_ovf_vec_clr;
    ovf_vec_ack_i && !max_wrap_i && !bottom_turn_i |-> ##2 !irq_ovf_o;
  endproperty
  a_ovf_vec_clr: assert property (p_ovf_vec_clr) else $error("overflow flag kept after vector");

  c_irq_cmp: cover property (irq_cmp_o);
  c_ext_buf: cover property (ext_buf_en_o);
  c_cnt_load: cover property (cnt_load_o);
  c_psr_both: cover property (prescaler_reset_timer_zero_o && prescaler_reset_timer_one_o);
endmodule // tmas_top_asserts

bind tmas_top tmas_top_asserts i_tmas_top_asserts (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .clk_src_ok_i, .gie_i, .cnt_live_i, .cmp_match_i, .max_wrap_i,
  .bottom_turn_i, .cmp_vec_ack_i, .ovf_vec_ack_i, .cnt_load_o, .ext_buf_en_o, .osc_run_o, .prescaler_reset_timer_zero_o,
  .prescaler_reset_timer_one_o, .irq_cmp_o, .irq_ovf_o);

// ---- dv/test_tmas_top.sv ----
// Purpose: register-level tests of the timer0 async/status block
// Assumes: ack arrives one cycle after each request
// Notes: the timer clock pin is driven slowly, only in the async phase
`timescale 1ns/1ns
`include "tmas_cfg.svh"

module test_tmas_top
  import tmas_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [4:0] wb_adr_i = 5'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic async_clk_i = 1'b0, clk_src_ok_i = 1'b0, gie_i = 1'b0;
  logic [7:0] cnt_live_i = 8'h00;
  logic cmp_match_i = 1'b0, max_wrap_i = 1'b0, bottom_turn_i = 1'b0, cmp_vec_ack_i = 1'b0, ovf_vec_ack_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic [7:0] cnt_load_val_o, cmp_a_o, ctrl_a_o, ctrl_b_o;
  logic [1:0] tmr_clk_src_o;
  logic wb_ack_o, cnt_load_o, force_cmp_o, ext_buf_en_o, osc_run_o, prescaler_reset_timer_zero_o, prescaler_reset_timer_one_o, irq_cmp_o, irq_ovf_o;
  int error_cnt = 0, cmp_count = 0, cyc_n = 0;

  tmas_top i_tmas_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .async_clk_i, .clk_src_ok_i, .gie_i, .cnt_live_i, .cmp_match_i, .max_wrap_i,
    .bottom_turn_i, .cmp_vec_ack_i, .ovf_vec_ack_i, .cnt_load_o, .cnt_load_val_o, .cmp_a_o, .ctrl_a_o,
    .ctrl_b_o, .force_cmp_o, .tmr_clk_src_o, .ext_buf_en_o, .osc_run_o, .prescaler_reset_timer_zero_o, .prescaler_reset_timer_one_o, .irq_cmp_o,
    .irq_ovf_o);

  always #4 clk_i = ~clk_i;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle, then one idle cycle
  task automatic xfer(input logic [4:0] a, input logic we, input logic [7:0] d, output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h00_0000, d};
    // only the bench timeout ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] q;
    xfer(a, 1'b0, 8'h00, q);
    chk(q, {24'h00_0000, e});
  endtask

  task automatic apulse();
    async_clk_i <= 1'b1;
    tick(8);
    async_clk_i <= 1'b0;
    tick(4);
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    tick(3);
    rst_i <= 1'b0;
    tick(1);
    for (int i = 0; i < 4; i++) begin
      rd(5'(4 * i), 8'h00);
    end
    chk(32'(osc_run_o), 32'h1);
    rd(5'h02, 8'h00);
    wr(`TMAS_OFF_MASK, 8'hFF);
    rd(`TMAS_OFF_MASK, 8'h03);
    cnt_live_i <= 8'hA5;
    tick(1);
    rd(`TMAS_OFF_CNT, 8'hA5);
    wr(`TMAS_OFF_CMPA, 8'h5A);
    rd(`TMAS_OFF_CMPA, 8'h5A);
    wr(`TMAS_OFF_CTLA, 8'hFF);
    rd(`TMAS_OFF_CTLA, 8'hC3);
    wr(`TMAS_OFF_CTLB, 8'h7F);
    rd(`TMAS_OFF_CTLB, 8'h07);
    $display("test registers done");
    cmp_match_i <= 1'b1;
    tick(1);
    cmp_match_i <= 1'b0;
    tick(2);
    chk(32'(irq_cmp_o), 32'h0);
    rd(`TMAS_OFF_FLAG, 8'h02);
    gie_i <= 1'b1;
    tick(2);
    chk(32'(irq_cmp_o), 32'h1);
    wr(`TMAS_OFF_FLAG, 8'h02);
    rd(`TMAS_OFF_FLAG, 8'h00);
    chk(32'(irq_cmp_o), 32'h0);
    // compare flag cleared by its vector instead of a write
    cmp_match_i <= 1'b1;
    tick(1);
    cmp_match_i <= 1'b0;
    cmp_vec_ack_i <= 1'b1;
    tick(1);
    cmp_vec_ack_i <= 1'b0;
    tick(2);
    chk(32'(irq_cmp_o), 32'h0);
    rd(`TMAS_OFF_FLAG, 8'h00);
    max_wrap_i <= 1'b1;
    tick(1);
    max_wrap_i <= 1'b0;
    tick(2);
    chk(32'(irq_ovf_o), 32'h1);
    ovf_vec_ack_i <= 1'b1;
    tick(1);
    ovf_vec_ack_i <= 1'b0;
    tick(2);
    chk(32'(irq_ovf_o), 32'h0);
    wr(`TMAS_OFF_CTLA, 8'h01);
    bottom_turn_i <= 1'b1;
    tick(1);
    bottom_turn_i <= 1'b0;
    tick(2);
    rd(`TMAS_OFF_FLAG, 8'h01);
    chk(32'(irq_ovf_o), 32'h1);
    wr(`TMAS_OFF_MASK, 8'h00);
    tick(1);
    chk(32'(irq_ovf_o), 32'h0);
    wr(`TMAS_OFF_FLAG, 8'h01);
    $display("test interrupts done");
    wr(`TMAS_OFF_ASYNC_CLOCK_STATUS, 8'h20);
    rd(`TMAS_OFF_ASYNC_CLOCK_STATUS, 8'h00);
    clk_src_ok_i <= 1'b1;
    wr(`TMAS_OFF_ASYNC_CLOCK_STATUS, 8'h40);
    wr(`TMAS_OFF_ASYNC_CLOCK_STATUS, 8'h60);
    tick(1);
    rd(`TMAS_OFF_ASYNC_CLOCK_STATUS, 8'h60);
    chk(32'(ext_buf_en_o), 32'h1);
    chk(32'(osc_run_o), 32'h0);
    chk(32'(tmr_clk_src_o), 32'(TMAS_SRC_EXT));
    // each held register written once, none while busy
    wr(`TMAS_OFF_CNT, 8'h33);
    wr(`TMAS_OFF_CMPA, 8'h44);
    wr(`TMAS_OFF_CTLA, 8'h00);
    wr(`TMAS_OFF_CTLB, 8'h82);
    rd(`TMAS_OFF_ASYNC_CLOCK_STATUS, 8'h7B);
    chk(32'(cmp_a_o), 32'h5A);
    chk(32'(ctrl_a_o), 32'h01);
    async_clk_i <= 1'b1;
    for (int n = 0; n < 12 && cnt_load_o !== 1'b1; n++) begin
      tick(1);
    end
    chk(32'(cnt_load_o), 32'h1);
    chk(32'(cnt_load_val_o), 32'h33);
    chk(32'(force_cmp_o), 32'h1);
    tick(6);
    async_clk_i <= 1'b0;
    tick(4);
    rd(`TMAS_OFF_ASYNC_CLOCK_STATUS, 8'h60);
    chk(32'(cmp_a_o), 32'h44);
    chk(32'(ctrl_b_o), 32'h02);
    chk(32'(ctrl_a_o), 32'h00);
    wr(`TMAS_OFF_GTC, 8'h02);
    rd(`TMAS_OFF_GTC, 8'h02);
    chk(32'(prescaler_reset_timer_zero_o), 32'h1);
    apulse();
    rd(`TMAS_OFF_GTC, 8'h00);
    clk_src_ok_i <= 1'b0;
    tick(2);
    rd(`TMAS_OFF_ASYNC_CLOCK_STATUS, 8'h40);
    $display("test async done");
    wr(`TMAS_OFF_ASYNC_CLOCK_STATUS, 8'h00);
    wr(`TMAS_OFF_CNT, 8'h00);
    wr(`TMAS_OFF_CMPA, 8'h10);
    wr(`TMAS_OFF_CTLA, 8'h00);
    chk(32'(tmr_clk_src_o), 32'(TMAS_SRC_IO));
    chk(32'(osc_run_o), 32'h1);
    wr(`TMAS_OFF_GTC, 8'h02);
    rd(`TMAS_OFF_GTC, 8'h00);
    wr(`TMAS_OFF_GTC, 8'h83);
    tick(2);
    rd(`TMAS_OFF_GTC, 8'h83);
    chk(32'({prescaler_reset_timer_zero_o, prescaler_reset_timer_one_o}), 32'h3);
    wr(`TMAS_OFF_GTC, 8'h03);
    tick(1);
    chk(32'({prescaler_reset_timer_zero_o, prescaler_reset_timer_one_o}), 32'h0);
    rd(`TMAS_OFF_GTC, 8'h00);
    $display("test prescaler done");
    close_out();
  end
endmodule // test_tmas_top
